// ### verilog/psru_updown.sv
// pid target setpoint 1 raise/lower/clear logic with apb registers
// Overview of operation
// R1 - raise input increases, lower input decreases setpoint
// R2 - adjust for parameter or multi-stage sources
// R3 - analog sources adjust only while hold on
// R4 - save option stores setpoint at poweroff/switch
// R5 - separate ramp times, 0 to 3600 s
// R6 - clear restores zero or saved value
// R7 - target select routes adjustments to setpoint
// R8 - far side: no toggling right after poweroff; not handled here, no lockout after powerOffReq
// R9 - both on holds; never below zero
//
// The address map and register access over APB were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
`include "psru_cfg.svh"
module psru_updown #(
  parameter int TickCyc = `PSRU_TICK_CYC, // cycles per 10 ms ramp step
  parameter int SpanW = 16 // setpoint width, full scale = all ones
) (
  input wire logic clk, // 100 MHz clock
  input wire logic rst, // sync reset, active high
  input wire psru_pkg::psru_term_s termPins, // raw terminal inputs
  input wire logic powerOffReq, // power-off warning pulse, same clock
  input wire logic [11:0] paddr, // apb address
  input wire logic psel, // apb select
  input wire logic penable, // apb enable
  input wire logic pwrite, // apb direction
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error
  output logic [SpanW-1:0] pidSetpoint, // setpoint to pid path
  output logic [SpanW-1:0] freqAdjust // adjusted frequency command
);
  localparam logic [SpanW-1:0] FullScale = '1;
  // terminal synchronisers
  psru_pkg::psru_term_s termMeta_q, term_q;
  always_ff @(posedge clk) begin
    if (rst) begin
      termMeta_q <= '0;
      term_q <= '0;
    end else begin
      termMeta_q <= termPins;
      term_q <= termMeta_q;
    end
  end
  // previous synced clear level; resets to the idle low level so no false edge follows reset
  logic clrPrev_q;
  always_ff @(posedge clk) begin
    if (rst) clrPrev_q <= 1'b0;
    else clrPrev_q <= term_q.clear;
  end
  wire logic clrRise = term_q.clear & ~clrPrev_q;
  // control registers
  logic [31:0] ctrl_q, accTime_q, decTime_q;
  logic [SpanW-1:0] base_q, saved_q, setp_q, freq_q;
  wire logic [3:0] srcSel = ctrl_q[`PSRU_CTRL_SRC_LO +: 4];
  wire logic tgtPid = ctrl_q[`PSRU_CTRL_TGT_BIT];
  wire logic saveEn = ctrl_q[`PSRU_CTRL_SAVE_BIT];
  wire logic clrSaved = ctrl_q[`PSRU_CTRL_CLR_BIT];
  wire logic apbWr = psel & penable & pwrite;
  wire logic apbAcc = psel & penable;
  // decode helper
  function automatic logic hit(input logic [11:0] a, input logic [11:0] o);
    hit = (a == o);
  endfunction
  // software writes ctrl; writing the switch bit pulses a source change
  logic srcSwitch;
  always_comb srcSwitch = apbWr & hit(paddr, `PSRU_OFS_CTRL) & pwdata[`PSRU_CTRL_SW_BIT];
  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl_q <= `PSRU_CTRL_RST;
      accTime_q <= `PSRU_RAMP_DEF;
      decTime_q <= `PSRU_RAMP_DEF;
      base_q <= '0;
    end else if (apbWr) begin
      // bit 7 is a strobe only and always reads back as zero
      if (hit(paddr, `PSRU_OFS_CTRL)) ctrl_q <= {25'h0, pwdata[6:0]};
      // ramp times above the longest allowed setting are clamped, not refused
      if (hit(paddr, `PSRU_OFS_ACC)) accTime_q <= (pwdata > `PSRU_RAMP_MAX) ? `PSRU_RAMP_MAX : pwdata; // R5
      if (hit(paddr, `PSRU_OFS_DEC)) decTime_q <= (pwdata > `PSRU_RAMP_MAX) ? `PSRU_RAMP_MAX : pwdata; // R5
      if (hit(paddr, `PSRU_OFS_BASE)) base_q <= pwdata[SpanW-1:0];
    end
  end
  // adjustment permission by source
  logic adjAllowed;
  always_comb begin
    case (srcSel)
      `PSRU_SRC_PARAM, `PSRU_SRC_MULTI: adjAllowed = 1'b1; // R2
      `PSRU_SRC_VOLT, `PSRU_SRC_CURR: adjAllowed = term_q.hold; // R3
      default: adjAllowed = 1'b0;
    endcase
  end
  // direction decision
  psru_pkg::psru_dir_e dir;
  always_comb begin
    if (!adjAllowed || (term_q.raise && term_q.lower)) dir = psru_pkg::DIR_HOLD; // R9
    else if (term_q.raise) dir = psru_pkg::DIR_UP; // R1
    else if (term_q.lower) dir = psru_pkg::DIR_DOWN; // R1
    else dir = psru_pkg::DIR_HOLD;
  end
  // 10 ms tick divider
  logic [31:0] tickCnt_q;
  wire logic tick = (tickCnt_q == 32'(TickCyc - 1));
  always_ff @(posedge clk) begin
    if (rst || tick) tickCnt_q <= '0;
    else tickCnt_q <= tickCnt_q + 32'd1;
  end
  // step per tick: full scale over ramp time; time zero jumps a full scale
  function automatic logic [SpanW-1:0] stepOf(input logic [31:0] t);
    logic [31:0] s;
    s = (t == 32'd0) ? 32'(FullScale) : (32'(FullScale) / t);
    stepOf = (s == 32'd0) ? SpanW'(1) : s[SpanW-1:0];
  endfunction
  wire logic [SpanW-1:0] upStep = stepOf(accTime_q);
  wire logic [SpanW-1:0] dnStep = stepOf(decTime_q);
  // adjusted value; routed to pid setpoint or frequency command
  wire logic [SpanW-1:0] cur = tgtPid ? setp_q : freq_q; // R7
  logic [SpanW-1:0] nxt;
  always_comb begin
    nxt = cur;
    if (clrRise) nxt = clrSaved ? saved_q : '0; // R6
    else if (tick && dir == psru_pkg::DIR_UP)
      nxt = (FullScale - cur < upStep) ? FullScale : cur + upStep; // R1
    else if (tick && dir == psru_pkg::DIR_DOWN)
      nxt = (cur < dnStep) ? '0 : cur - dnStep; // R9
  end
  // setpoint storage; a base write reloads it
  always_ff @(posedge clk) begin
    if (rst) begin
      setp_q <= '0;
      freq_q <= '0;
    end else if (apbWr && hit(paddr, `PSRU_OFS_BASE)) begin
      setp_q <= pwdata[SpanW-1:0];
      freq_q <= pwdata[SpanW-1:0];
    end else if (tgtPid) setp_q <= nxt; // R7
    else freq_q <= nxt; // R7
  end
  // saved copy in internal memory
  always_ff @(posedge clk) begin
    if (rst) saved_q <= '0;
    else if (saveEn && (powerOffReq || srcSwitch)) saved_q <= cur; // R4
  end
  // both values leave straight from their flops
  always_comb pidSetpoint = setp_q;
  always_comb freqAdjust = freq_q;
  // apb read side, zero wait states
  always_comb pready = 1'b1;
  // addresses past the status word answer with an error
  always_comb begin
    pslverr = 1'b0;
    if (apbAcc && paddr > `PSRU_OFS_STAT) pslverr = 1'b1;
  end
  // read data is captured in the setup phase so it stands through the access phase
  always_ff @(posedge clk) begin
    if (rst) prdata <= '0;
    else if (psel && !penable && !pwrite) begin
      case (paddr)
        `PSRU_OFS_CTRL: prdata <= ctrl_q;
        `PSRU_OFS_ACC: prdata <= accTime_q;
        `PSRU_OFS_DEC: prdata <= decTime_q;
        `PSRU_OFS_BASE: prdata <= 32'(base_q);
        `PSRU_OFS_SETP: prdata <= 32'(cur);
        `PSRU_OFS_SAVED: prdata <= 32'(saved_q);
        `PSRU_OFS_STAT: prdata <= {26'h0, dir, term_q};
        default: prdata <= '0;
      endcase
    end
  end
  // assertions
  hold_both_a: assert property (@(posedge clk) disable iff (rst) // R9
    term_q.raise && term_q.lower && !clrRise && !apbWr |=> $stable(cur))
    else $error("setpoint moved with both inputs on");
  clear_zero_a: assert property (@(posedge clk) disable iff (rst) // R6
    clrRise && !clrSaved && !apbWr |=> cur == '0)
    else $error("clear did not zero setpoint");
  save_copy_a: assert property (@(posedge clk) disable iff (rst) // R4
    saveEn && powerOffReq |=> saved_q == $past(cur))
    else $error("save missed");
  nosave_a: assert property (@(posedge clk) disable iff (rst) // R4
    !saveEn |=> $stable(saved_q))
    else $error("saved value changed with save off");
  analog_gate_a: assert property (@(posedge clk) disable iff (rst) // R3
    (srcSel == `PSRU_SRC_VOLT || srcSel == `PSRU_SRC_CURR) && !term_q.hold |-> dir == psru_pkg::DIR_HOLD)
    else $error("analog source adjusted without hold");
  raise_up_a: assert property (@(posedge clk) disable iff (rst) // R1
    tick && dir == psru_pkg::DIR_UP && !clrRise && !apbWr |=> cur >= $past(cur))
    else $error("raise decreased setpoint");
  lower_dn_a: assert property (@(posedge clk) disable iff (rst) // R1
    tick && dir == psru_pkg::DIR_DOWN && !clrRise && !apbWr |=> cur <= $past(cur))
    else $error("lower increased setpoint");
  ramp_cap_a: assert property (@(posedge clk) disable iff (rst) // R5
    accTime_q <= `PSRU_RAMP_MAX && decTime_q <= `PSRU_RAMP_MAX)
    else $error("ramp time above limit");
  // a clear in saved-value mode with no bus write in the way
  sequence clrToSaved_s;
    clrRise && clrSaved && !apbWr;
  endsequence
  clear_saved_a: assert property (@(posedge clk) disable iff (rst) // R6
    clrToSaved_s |=> cur == $past(saved_q))
    else $error("clear did not restore saved value");
  // a source switch stores the live value when saving is on
  switch_save_a: assert property (@(posedge clk) disable iff (rst) // R4
    saveEn && srcSwitch |=> saved_q == $past(cur))
    else $error("source switch did not save");
  // a raise step that would pass full scale stops at full scale
  ceiling_stop_a: assert property (@(posedge clk) disable iff (rst) // R1
    tick && dir == psru_pkg::DIR_UP && (FullScale - cur < upStep) && !clrRise && !apbWr
    |=> cur == FullScale)
    else $error("raise did not stop at full scale");
  // a lower step that would pass zero stops at zero
  floor_stop_a: assert property (@(posedge clk) disable iff (rst) // R9
    tick && dir == psru_pkg::DIR_DOWN && (cur < dnStep) && !clrRise && !apbWr
    |=> cur == '0)
    else $error("lower went past zero");
  // source codes outside the adjustable set never raise or lower the setpoint
  source_gate_a: assert property (@(posedge clk) disable iff (rst) // R2
    !(srcSel inside {`PSRU_SRC_PARAM, `PSRU_SRC_MULTI, `PSRU_SRC_VOLT, `PSRU_SRC_CURR})
    |-> dir == psru_pkg::DIR_HOLD)
    else $error("unknown source moved the setpoint");
  // with the frequency command targeted the pid setpoint is left alone
  target_route_a: assert property (@(posedge clk) disable iff (rst) // R7
    !tgtPid && !apbWr |=> $stable(setp_q))
    else $error("pid setpoint moved while frequency targeted");
endmodule // psru_updown
`default_nettype wire

// ### shared/psru_cfg.svh
// constants for the pid setpoint raise/lower block
`ifndef PSRU_CFG_SVH
`define PSRU_CFG_SVH
// register byte offsets
`define PSRU_OFS_CTRL 12'h000
`define PSRU_OFS_ACC 12'h004
`define PSRU_OFS_DEC 12'h008
`define PSRU_OFS_BASE 12'h00C
`define PSRU_OFS_SETP 12'h010
`define PSRU_OFS_SAVED 12'h014
`define PSRU_OFS_STAT 12'h018
// ctrl field positions
`define PSRU_CTRL_SRC_LO 0
`define PSRU_CTRL_TGT_BIT 4
`define PSRU_CTRL_SAVE_BIT 5
`define PSRU_CTRL_CLR_BIT 6
`define PSRU_CTRL_SW_BIT 7
// ctrl after reset: parameter source, frequency target, save off, clear to zero
`define PSRU_CTRL_RST 32'h00000007
// source codes
`define PSRU_SRC_VOLT 4'h1
`define PSRU_SRC_CURR 4'h2
`define PSRU_SRC_PARAM 4'h7
`define PSRU_SRC_MULTI 4'h8
// ramp times in units of 10 ms, default 10.00 s, max 3600.00 s
`define PSRU_RAMP_DEF 32'd1000
`define PSRU_RAMP_MAX 32'd360000
// ramp tick: 10 ms at 100 MHz (10 ns period)
`define PSRU_TICK_NS 32'd10000000
`define PSRU_CLK_NS 32'd10
`define PSRU_TICK_CYC (`PSRU_TICK_NS / `PSRU_CLK_NS)
`endif

// ### shared/psru_pkg.sv
// types for the pid setpoint raise/lower block
package psru_pkg;
  typedef enum logic [1:0] {
    DIR_HOLD,
    DIR_UP,
    DIR_DOWN
  } psru_dir_e;
  typedef struct packed {
    logic raise;
    logic lower;
    logic clear;
    logic hold;
  } psru_term_s;
endpackage

// ### test/psru_switch_model.sv
// switch or controller model that drives the terminal inputs
`timescale 1ns/1ns
`default_nettype none
module psru_switch_model (
  input wire logic clk, // bench clock
  output var psru_pkg::psru_term_s termPins // terminal levels
);
  initial termPins = '0;
  // new levels land just after a rising edge and stay steady until the next call
  task automatic drive(input psru_pkg::psru_term_s v);
    @(posedge clk);
    termPins <= v;
  endtask
endmodule // psru_switch_model
`default_nettype wire

// ### test/testbench.sv
// self-checking bench for the setpoint raise/lower block
`timescale 1ns/1ns
`default_nettype none
module testbench;
  typedef struct packed {logic [31:0] c; logic [3:0] p; logic [15:0] e;} psru_row_s;
  logic clk, rst, powerOffReq, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] pidSetpoint, freqAdjust;
  psru_pkg::psru_term_s termPins;
  int miscompares = 0, checks = 0;
  // ctrl value, terminal levels {raise,lower,clear,hold}, expected setpoint
  psru_row_s rows[8] = '{'{32'h37, 4'h8, 16'hFFFF}, '{32'h37, 4'hC, 16'hFFFF}, '{32'h37, 4'h4, 16'h0000},
    '{32'h30, 4'h8, 16'h0000}, '{32'h31, 4'h8, 16'h0000}, '{32'h31, 4'h9, 16'hFFFF}, '{32'h38, 4'h4, 16'h0000},
    '{32'h37, 4'h8, 16'hFFFF}};
  psru_updown #(.TickCyc(10)) psru_updown_inst (.clk(clk), .rst(rst), .termPins(termPins),
    .powerOffReq(powerOffReq), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .pidSetpoint(pidSetpoint),
    .freqAdjust(freqAdjust));
  psru_switch_model psru_switch_model_inst (.clk(clk), .termPins(termPins));
  // free-running 100 MHz clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // prints the counts and the verdict, then stops
  task automatic print_verdict;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // compare one value against its expectation
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // one apb transfer; read data and error taken at the ready edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 50) begin
      miscompares++;
      print_verdict();
    end
  endtask
  // set terminal levels and let sync plus a few ramp ticks pass
  task automatic term(input logic [3:0] v);
    psru_switch_model_inst.drive(v);
    repeat (40) @(posedge clk);
  endtask
  // main sequence
  initial begin
    rst = 1'b1;
    powerOffReq = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    apb(1'b0, 12'h000, 32'h0);
    check("ctrl", rd, 32'h07);
    apb(1'b0, 12'h004, 32'h0);
    check("raiseTime", rd, 32'h3E8);
    apb(1'b0, 12'h008, 32'h0);
    check("lowerTime", rd, 32'h3E8);
    apb(1'b0, 12'h01C, 32'h0);
    check("slverr", err, 32'h1);
    $display("test reset done");
    // zero ramp times jump a whole span per tick
    apb(1'b1, 12'h004, 32'h0);
    apb(1'b1, 12'h008, 32'h0);
    foreach (rows[i]) begin
      apb(1'b1, 12'h000, rows[i].c);
      term(rows[i].p);
      check("pidSetpoint", pidSetpoint, rows[i].e);
      term(4'h0);
    end
    check("freqAdjust", freqAdjust, 32'h0);
    $display("test table done");
    @(posedge clk);
    powerOffReq <= 1'b1;
    @(posedge clk);
    powerOffReq <= 1'b0;
    apb(1'b0, 12'h014, 32'h0);
    check("saved", rd, 32'hFFFF);
    term(4'h4);
    apb(1'b1, 12'h000, 32'h77);
    term(4'h2);
    check("clearSaved", pidSetpoint, 32'hFFFF);
    term(4'h0);
    apb(1'b1, 12'h000, 32'h37);
    term(4'h2);
    check("clearZero", pidSetpoint, 32'h0);
    $display("test save and clear done");
    // switch strobe saves the live value and reads back as zero
    apb(1'b1, 12'h000, 32'hB7);
    apb(1'b0, 12'h000, 32'h0);
    check("ctrlSwitch", rd, 32'h37);
    apb(1'b0, 12'h014, 32'h0);
    check("savedSwitch", rd, 32'h0);
    // with saving off a power-off warning leaves the stored copy alone
    apb(1'b1, 12'h000, 32'h17);
    term(4'h8);
    @(posedge clk);
    powerOffReq <= 1'b1;
    @(posedge clk);
    powerOffReq <= 1'b0;
    apb(1'b0, 12'h014, 32'h0);
    check("savedOff", rd, 32'h0);
    // frequency command targeted: only it moves
    apb(1'b1, 12'h000, 32'h07);
    term(4'h8);
    check("freqRaise", freqAdjust, 32'hFFFF);
    term(4'h4);
    check("freqLower", freqAdjust, 32'h0);
    check("pidKept", pidSetpoint, 32'hFFFF);
    term(4'h0);
    $display("test switch and target done");
    // ramp time clamp, base load and a measured ramp step from zero
    apb(1'b1, 12'h008, 32'hFFFFFFFF);
    apb(1'b0, 12'h008, 32'h0);
    check("lowerClamp", rd, 32'h00057E40);
    apb(1'b1, 12'h000, 32'h17);
    apb(1'b1, 12'h00C, 32'h1234);
    @(posedge clk);
    check("basePid", pidSetpoint, 32'h1234);
    check("baseFreq", freqAdjust, 32'h1234);
    apb(1'b0, 12'h010, 32'h0);
    check("adjusted", rd, 32'h1234);
    apb(1'b1, 12'h004, 32'h10);
    apb(1'b1, 12'h00C, 32'h0);
    term(4'h8);
    check("rampStep", 32'(pidSetpoint == 16'h2FFD || pidSetpoint == 16'h3FFC), 32'h1);
    $display("test ramp done");
    print_verdict();
  end
endmodule // testbench
`default_nettype wire
